/* verilog/vlcp_pkg.sv */
/*
  Package for the vertex lighting colour path: number format, register map,
  word layouts, reset values, state encoding and the vector helpers.
  Assumes a single 100 MHz APB clock domain and signed fixed-point reals.
*/
package vlcp_pkg;

  // ==========================================================================
  // Number format: signed fixed point, 12 fraction bits
  localparam int VW    = 24;
  localparam int FRAC  = 12;
  localparam int CW    = 8;
  localparam int IDX_W = 12;
  localparam int AW    = 12;

  typedef logic signed [VW-1:0]  vlcp_fx_t;
  typedef logic [3:0][VW-1:0]    vlcp_vec4_t;
  typedef logic [2:0][VW-1:0]    vlcp_vec3_t;
  typedef logic [3:0][CW-1:0]    vlcp_rgba8_t;

  localparam vlcp_fx_t FX_ZERO = 24'h000000;
  localparam vlcp_fx_t FX_ONE  = 24'h001000;
  localparam vlcp_fx_t FX_0P2  = 24'h000333;
  localparam vlcp_fx_t FX_0P8  = 24'h000CCD;
  localparam vlcp_fx_t FX_M1   = 24'hFFF000;
  localparam vlcp_fx_t FX_90   = 24'h05A000;
  localparam vlcp_fx_t FX_128  = 24'h080000;
  localparam vlcp_fx_t FX_180  = 24'h0B4000;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [AW-1:0] ADDR_CTRL   = 12'h000;
  localparam logic [AW-1:0] ADDR_IMASK  = 12'h004;
  localparam logic [AW-1:0] ADDR_STATUS = 12'h008;
  localparam logic [AW-1:0] MAT_BASE    = 12'h100;
  localparam logic [AW-1:0] MODEL_BASE  = 12'h180;
  localparam logic [AW-1:0] LIGHT_BASE  = 12'h200;
  localparam int            BLK_SH      = 7;
  localparam int            MAT_WORDS   = 20;
  localparam int            MODEL_WORDS = 4;
  localparam int            LW          = 24;

  // Control bits
  localparam int B_LIGHTING = 0;
  localparam int B_CLAMP    = 1;
  localparam int B_FLAT     = 2;
  localparam int B_INDEX    = 3;
  localparam int B_SIGNED   = 4;
  localparam int B_LOCAL_VW = 5;
  localparam int B_COLOR_CS = 6;
  localparam int B_TWO_SIDE = 7;
  localparam int B_LEN      = 8;
  localparam int STAT_CNT   = 16;

  // Word positions inside the material, model and per-light blocks
  localparam int W_AMB   = 0;
  localparam int W_DIF   = 4;
  localparam int W_SPEC  = 8;
  localparam int W_EMIS  = 12;
  localparam int W_SHIN  = 16;
  localparam int W_IAMB  = 17;
  localparam int W_IDIF  = 18;
  localparam int W_ISPEC = 19;
  localparam int W_POS   = 12;
  localparam int W_SDIR  = 16;
  localparam int W_SEXP  = 19;
  localparam int W_CUT   = 20;
  localparam int W_K0    = 21;
  localparam int W_K1    = 22;
  localparam int W_K2    = 23;
  localparam int C_A     = 3;

  typedef enum logic [1:0] {ST_IDLE, ST_LIGHT, ST_FINISH, ST_OUT} vlcp_state_t;

  // ==========================================================================
  // Arithmetic helpers
  function automatic vlcp_fx_t fmul(input vlcp_fx_t a, input vlcp_fx_t b);
    logic signed [2*VW-1:0] p;
    p = $signed(a) * $signed(b);
    return p[FRAC+VW-1:FRAC];
  endfunction : fmul

  function automatic vlcp_fx_t dot_clamp(input vlcp_vec3_t a, input vlcp_vec3_t b);
    vlcp_fx_t d;
    d = fmul(a[0], b[0]) + fmul(a[1], b[1]) + fmul(a[2], b[2]);
    return (d < 0) ? FX_ZERO : d;
  endfunction : dot_clamp

  // Direction from p1 towards p2; inputs are assumed already unit length
  function automatic vlcp_vec3_t dir_to(input vlcp_vec4_t p1, input vlcp_vec4_t p2);
    vlcp_vec3_t d;
    for (int k = 0; k < 3; k++) begin
      if (p2[C_A] == FX_ZERO && p1[C_A] != FX_ZERO) begin
        d[k] = p2[k];
      end else if (p1[C_A] == FX_ZERO && p2[C_A] != FX_ZERO) begin
        d[k] = -$signed(p1[k]);
      end else begin
        d[k] = $signed(p2[k]) - $signed(p1[k]);
      end
    end
    return d;
  endfunction : dir_to

  // Unsigned c maps to c/255, approximated by c*16 + c/16
  function automatic vlcp_fx_t conv_u(input logic [CW-1:0] c);
    return {12'h000, c, 4'h0} + {20'h00000, c[7:4]};
  endfunction : conv_u

  // Signed c maps to (2c+1)/255 with the same approximation
  function automatic vlcp_fx_t conv_s(input logic [CW-1:0] c);
    vlcp_fx_t v;
    v = {{15{c[7]}}, c, 1'b1};
    return (v <<< 4) + (v >>> 4);
  endfunction : conv_s

  function automatic vlcp_fx_t clamp01(input vlcp_fx_t x);
    if (x < 0) begin
      return FX_ZERO;
    end
    return (x > FX_ONE) ? FX_ONE : x;
  endfunction : clamp01

  function automatic vlcp_fx_t mix(input vlcp_fx_t a, input vlcp_fx_t b, input vlcp_fx_t t);
    return a + fmul(t, b - a);
  endfunction : mix

endpackage : vlcp_pkg

/* verilog/vlcp_color_path.sv */
/*
  Vertex colour path: APB parameter store, input conversion, lighting,
  clamp / index mask, flat shading and clip-vertex colour recomputation.
  Assumes upstream hands one vertex at a time with a valid/ready handshake
  and that stored directions and normals are already unit length.
*/
// Operation
// - Integer RGBA inputs converted to fixed-point reals
// - Colour index passes input unmapped
// - Lighting off passes current colours through
// - Lighting on outputs colours from stored parameters
// - Optional clamp of RGBA into zero..one
// - Index made fixed-point, integer part masked
// - Flat shading copies provoking vertex colours
// - Clip vertices get recomputed colours and texcoords
// - Colour parameters hold four values RGBA
// - Positions four coords, directions three, reals one
// - At least eight lights, indexed from zero
// - Colour arithmetic is component by component
// - Direction product clamps negative dot to zero
// - Finite to infinite point uses its direction
// - Infinite start negates; both infinite subtract
// - Material defaults and shininess range
// - Light intensity defaults, light zero differs
// - Light position and spot direction defaults
// - Cutoff defaults 180, accepts 0..90 or 180
// - Attenuation defaults, non-negative only
// - Scene ambient and model flag defaults
`timescale 1ns/1ns
module vlcp_color_path #(
  parameter int NUM_LIGHTS = 8
) (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [vlcp_pkg::AW-1:0]     paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Vertex input
  input  wire logic                        in_valid,
  output logic                             in_ready,
  input  wire vlcp_pkg::vlcp_rgba8_t       in_color,
  input  wire vlcp_pkg::vlcp_rgba8_t       in_sec_color,
  input  wire logic [vlcp_pkg::IDX_W-1:0]  in_index,
  input  wire vlcp_pkg::vlcp_vec3_t        in_normal,
  input  wire vlcp_pkg::vlcp_vec4_t        in_position,
  input  wire logic [1:0][vlcp_pkg::VW-1:0] in_tex,
  input  wire logic                        in_first,
  input  wire logic                        in_clip,
  input  wire vlcp_pkg::vlcp_fx_t          in_clip_t,
  input  wire logic                        in_last,
  // Vertex output
  output logic                             out_valid,
  input  wire logic                        out_ready,
  output vlcp_pkg::vlcp_vec4_t             out_pri,
  output vlcp_pkg::vlcp_vec4_t             out_sec,
  output vlcp_pkg::vlcp_fx_t               out_index,
  output logic [1:0][vlcp_pkg::VW-1:0]     out_tex,
  output logic                             out_last
);
  import vlcp_pkg::*;

  localparam int LIW = $clog2(NUM_LIGHTS + 1);

  // ==========================================================================
  // State
  typedef struct packed {
    vlcp_state_t                          state;
    logic [31:0]                          ctrl;
    logic [IDX_W-1:0]                     idx_mask;
    logic [MAT_WORDS-1:0][VW-1:0]         mat;
    logic [MODEL_WORDS-1:0][VW-1:0]       model;
    logic [NUM_LIGHTS-1:0][LW-1:0][VW-1:0] light;
    vlcp_vec4_t                           v_col;
    vlcp_vec4_t                           v_sec;
    vlcp_vec3_t                           v_nrm;
    vlcp_vec4_t                           v_pos;
    logic [IDX_W-1:0]                     v_idx;
    logic [1:0][VW-1:0]                   v_tex;
    logic                                 v_first;
    logic                                 v_clip;
    vlcp_fx_t                             v_t;
    logic                                 v_last;
    vlcp_vec4_t                           acc;
    logic [LIW-1:0]                       li;
    vlcp_vec4_t                           flat_pri;
    vlcp_vec4_t                           flat_sec;
    vlcp_fx_t                             flat_idx;
    vlcp_vec4_t                           prev_pri;
    vlcp_vec4_t                           prev_sec;
    vlcp_fx_t                             prev_idx;
    logic [1:0][VW-1:0]                   prev_tex;
    logic                                 in_ready;
    logic                                 out_valid;
    vlcp_vec4_t                           out_pri;
    vlcp_vec4_t                           out_sec;
    vlcp_fx_t                             out_idx;
    logic [1:0][VW-1:0]                   out_tex;
    logic                                 out_last;
    logic [31:0]                          prdata;
    logic                                 pready;
    logic                                 pslverr;
    logic [15:0]                          vcount;
  } vlcp_st_t;

  function automatic vlcp_st_t rst_val();
    vlcp_st_t r;
    r = '0;
    for (int k = 0; k < 3; k++) begin
      r.mat[W_AMB + k] = FX_0P2;
      r.mat[W_DIF + k] = FX_0P8;
      r.model[k]       = FX_0P2;
    end
    r.mat[W_AMB + C_A]  = FX_ONE;
    r.mat[W_DIF + C_A]  = FX_ONE;
    r.mat[W_SPEC + C_A] = FX_ONE;
    r.mat[W_EMIS + C_A] = FX_ONE;
    r.mat[W_IDIF]       = FX_ONE;
    r.mat[W_ISPEC]      = FX_ONE;
    // scene ambient alpha; model flags clear
    r.model[C_A] = FX_ONE;
    for (int i = 0; i < NUM_LIGHTS; i++) begin
      for (int k = 0; k < 4; k++) begin
        r.light[i][W_DIF + k]  = (i == 0 || k == C_A) ? FX_ONE : FX_ZERO;
        r.light[i][W_SPEC + k] = (i == 0 || k == C_A) ? FX_ONE : FX_ZERO;
      end
      r.light[i][W_AMB + C_A] = FX_ONE;
      r.light[i][W_POS + 2]  = FX_ONE;
      r.light[i][W_SDIR + 2] = FX_M1;
      r.light[i][W_CUT] = FX_180;
      r.light[i][W_K0] = FX_ONE;
    end
    return r;
  endfunction : rst_val

  localparam vlcp_st_t ST_RST = rst_val();

  vlcp_st_t s;
  vlcp_st_t n;

  // ==========================================================================
  // Next-state logic
  logic             a_setup;
  logic             a_do;
  logic             hit;
  logic             legal;
  logic             ro;
  logic [31:0]      rd;
  logic [4:0]       wrd;
  logic [AW-1:0]    lsel;
  vlcp_fx_t         wv;
  vlcp_fx_t         ndl;
  vlcp_vec4_t       pri;
  vlcp_vec4_t       sec;
  vlcp_fx_t         idx;
  logic [1:0][VW-1:0] tex;
  logic             lit;

  always_comb begin
    n       = s;
    a_setup = psel && !penable;
    a_do    = psel && penable && s.pready;
    wrd     = paddr[BLK_SH-1:2];
    lsel    = (paddr - LIGHT_BASE) >> BLK_SH;
    wv      = pwdata[VW-1:0];
    hit     = 1'b0;
    legal   = 1'b1;
    ro      = 1'b0;
    rd      = '0;
    ndl     = FX_ZERO;
    pri     = '0;
    sec     = '0;
    idx     = FX_ZERO;
    tex     = s.v_tex;
    lit     = s.ctrl[B_LIGHTING];

    // ---- Register decode; narrow words read zero-extended
    if (paddr == ADDR_CTRL) begin
      hit = 1'b1;
      rd  = s.ctrl;
    end else if (paddr == ADDR_IMASK) begin
      hit = 1'b1;
      rd  = {{(32-IDX_W){1'b0}}, s.idx_mask};
    end else if (paddr == ADDR_STATUS) begin
      hit = 1'b1;
      ro  = 1'b1;
      rd  = {s.vcount, 15'h0000, s.state != ST_IDLE};
    end else if ((paddr >> BLK_SH) == (MAT_BASE >> BLK_SH) && wrd < MAT_WORDS) begin
      hit = 1'b1;
      rd  = {8'h00, s.mat[wrd]};
      if (wrd == W_SHIN) begin
        legal = (wv >= FX_ZERO) && (wv <= FX_128);
      end
    end else if ((paddr >> BLK_SH) == (MODEL_BASE >> BLK_SH) && wrd < MODEL_WORDS) begin
      hit = 1'b1;
      rd  = {8'h00, s.model[wrd]};
    end else if (paddr >= LIGHT_BASE && lsel < AW'(NUM_LIGHTS) && wrd < LW) begin
      hit = 1'b1;
      rd  = {8'h00, s.light[lsel][wrd]};
      if (wrd == W_SEXP) begin
        legal = (wv >= FX_ZERO) && (wv <= FX_128);
      end
      if (wrd == W_CUT) begin
        legal = ((wv >= FX_ZERO) && (wv <= FX_90)) || (wv == FX_180);
      end
      if (wrd >= W_K0 && wrd <= W_K2) begin
        legal = (wv >= FX_ZERO);
      end
    end

    // ---- APB: answer in the first access cycle
    if (a_setup) begin
      n.pready  = 1'b1;
      n.prdata  = pwrite ? 32'h0000_0000 : rd;
      n.pslverr = !hit || (pwrite && (ro || !legal));
    end else if (a_do) begin
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      // Rejected writes leave the old value; the store never holds illegal ranges
      if (pwrite && !s.pslverr) begin
        if (paddr == ADDR_CTRL) begin
          n.ctrl = pwdata;
        end else if (paddr == ADDR_IMASK) begin
          n.idx_mask = pwdata[IDX_W-1:0];
        end else if ((paddr >> BLK_SH) == (MAT_BASE >> BLK_SH)) begin
          // colour words stored as R, G, B, A
          n.mat[wrd] = wv;
        end else if ((paddr >> BLK_SH) == (MODEL_BASE >> BLK_SH)) begin
          n.model[wrd] = wv;
        end else begin
          n.light[lsel][wrd] = wv;
        end
      end
    end

    // ---- Vertex pipeline
    case (s.state)
      ST_IDLE: begin
        if (in_valid && s.in_ready) begin
          for (int k = 0; k < 4; k++) begin
            n.v_col[k] = s.ctrl[B_SIGNED] ? conv_s(in_color[k]) : conv_u(in_color[k]);
            n.v_sec[k] = s.ctrl[B_SIGNED] ? conv_s(in_sec_color[k])
                                          : conv_u(in_sec_color[k]);
          end
          n.v_idx   = in_index;
          n.v_nrm   = in_normal;
          n.v_pos   = in_position;
          n.v_tex   = in_tex;
          n.v_first = in_first;
          n.v_clip  = in_clip;
          n.v_t     = in_clip_t;
          n.v_last  = in_last;
          n.li      = '0;
          // emission plus ambient product, per component
          for (int k = 0; k < 4; k++) begin
            n.acc[k] = $signed(s.mat[W_EMIS + k])
                     + fmul(s.mat[W_AMB + k], s.model[k]);
          end
          n.state = lit ? ST_LIGHT : ST_FINISH;
        end
      end
      ST_LIGHT: begin
        ndl = dot_clamp(s.v_nrm, dir_to(s.v_pos, s.light[s.li][W_POS +: 4]));
        if (s.ctrl[B_LEN + 32'(s.li)]) begin
          for (int k = 0; k < 3; k++) begin
            n.acc[k] = $signed(s.acc[k])
                     + fmul(s.mat[W_AMB + k], s.light[s.li][W_AMB + k])
                     + fmul(ndl, fmul(s.mat[W_DIF + k], s.light[s.li][W_DIF + k]));
          end
        end
        n.li = s.li + 1'b1;
        if (s.li == LIW'(NUM_LIGHTS - 1)) begin
          n.state = ST_FINISH;
        end
      end
      ST_FINISH: begin
        if (lit) begin
          // lit colours; alpha from material diffuse
          pri      = s.acc;
          pri[C_A] = s.mat[W_DIF + C_A];
          sec[C_A] = FX_ONE;
        end else begin
          pri = s.v_col;
          sec = s.v_sec;
        end
        if (s.ctrl[B_CLAMP]) begin
          for (int k = 0; k < 4; k++) begin
            pri[k] = clamp01(pri[k]);
            sec[k] = clamp01(sec[k]);
          end
        end
        // fixed-point index, mask on integer part only
        idx = {s.v_idx, {FRAC{1'b0}}};
        if (s.ctrl[B_INDEX]) begin
          idx[VW-1:FRAC] = s.v_idx & s.idx_mask;
        end
        // first vertex of the primitive provokes
        if (s.ctrl[B_FLAT]) begin
          if (s.v_first) begin
            n.flat_pri = pri;
            n.flat_sec = sec;
            n.flat_idx = idx;
          end else begin
            pri = s.flat_pri;
            sec = s.flat_sec;
            idx = s.flat_idx;
          end
        end
        // clip vertex: blend from previous vertex by t
        if (s.v_clip) begin
          for (int k = 0; k < 4; k++) begin
            pri[k] = mix(s.prev_pri[k], pri[k], s.v_t);
            sec[k] = mix(s.prev_sec[k], sec[k], s.v_t);
          end
          for (int k = 0; k < 2; k++) begin
            tex[k] = mix(s.prev_tex[k], s.v_tex[k], s.v_t);
          end
          idx = mix(s.prev_idx, idx, s.v_t);
        end
        n.prev_pri  = pri;
        n.prev_sec  = sec;
        n.prev_idx  = idx;
        n.prev_tex  = tex;
        n.out_pri   = pri;
        n.out_sec   = sec;
        n.out_idx   = idx;
        n.out_tex   = tex;
        n.out_last  = s.v_last;
        n.out_valid = 1'b1;
        n.state     = ST_OUT;
      end
      ST_OUT: begin
        if (out_ready) begin
          n.out_valid = 1'b0;
          n.vcount    = s.vcount + 16'h0001;
          n.state     = ST_IDLE;
        end
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase
    n.in_ready = (n.state == ST_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata    = s.prdata;
  assign pready    = s.pready;
  assign pslverr   = s.pslverr;
  assign in_ready  = s.in_ready;
  assign out_valid = s.out_valid;
  assign out_pri   = s.out_pri;
  assign out_sec   = s.out_sec;
  assign out_index = s.out_idx;
  assign out_tex   = s.out_tex;
  assign out_last  = s.out_last;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic acc_in;
  assign acc_in = in_valid && s.in_ready && s.state == ST_IDLE;

  AST_CONV_UNSIGNED: assert property (acc_in && !s.ctrl[B_SIGNED] |=>
    s.v_col[0] == conv_u($past(in_color[0]))) else $error("unsigned conversion wrong");
  AST_INDEX_RAW: assert property (acc_in |=> s.v_idx == $past(in_index))
    else $error("index altered at input");
  AST_UNLIT_PASS: assert property (acc_in && !lit |=> ##1
    (!s.ctrl[B_CLAMP] && !s.ctrl[B_FLAT] && !s.v_clip && s.ctrl == $past(s.ctrl, 2))
    |-> out_pri == $past(s.v_col)) else $error("unlit colour not passed");
  AST_LIT_ALPHA: assert property (s.state == ST_FINISH && lit && !s.ctrl[B_CLAMP]
    && !s.ctrl[B_FLAT] && !s.v_clip |=> out_pri[C_A] == $past(s.mat[W_DIF + C_A])
    && out_sec[C_A] == FX_ONE) else $error("lit alpha wrong");
  AST_CLAMP_RANGE: assert property (s.state == ST_FINISH && s.ctrl[B_CLAMP]
    && !s.ctrl[B_FLAT] && !s.v_clip |=> $signed(out_pri[0]) >= 0 && out_pri[0] <= FX_ONE)
    else $error("clamped colour out of range");
  AST_INDEX_MASK: assert property (s.state == ST_FINISH && s.ctrl[B_INDEX]
    && !s.ctrl[B_FLAT] && !s.v_clip |=> out_index[FRAC-1:0] == '0
    && (out_index[VW-1:FRAC] & ~$past(s.idx_mask)) == '0) else $error("mask wrong");
  AST_FLAT_COPY: assert property (s.state == ST_FINISH && s.ctrl[B_FLAT]
    && !s.v_first && !s.v_clip |=> out_pri == $past(s.flat_pri))
    else $error("flat colour not copied");
  AST_LIGHT_WALK: assert property (s.state == ST_LIGHT && s.li == '0
    |-> ##(NUM_LIGHTS) s.state == ST_FINISH) else $error("light walk length wrong");
  AST_CUTOFF_OK: assert property (s.light[0][W_CUT] == FX_180 ||
    ($signed(s.light[0][W_CUT]) >= 0 && s.light[0][W_CUT] <= FX_90))
    else $error("cutoff outside accepted range");
  AST_APB_ANSWER: assert property (psel && !penable |=> pready)
    else $error("apb answer late");

  COV_LIT: cover property (s.state == ST_FINISH && lit);
  COV_FLAT: cover property (s.state == ST_FINISH && s.ctrl[B_FLAT] && !s.v_first);
  COV_CLIP: cover property (s.state == ST_FINISH && s.v_clip);
  COV_BAD_WRITE: cover property (a_do && pwrite && s.pslverr);

endmodule : vlcp_color_path

/* sim/vlcp_sink.sv */
/*
  Downstream model of the colour path: the clip and raster stage that
  accepts vertices. Assumes the bench clock and active-low reset.
*/
`timescale 1ns/1ns
module vlcp_sink (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Stream
  input  wire logic slow,
  input  wire logic out_valid,
  output logic      out_ready
);
  logic [1:0] cnt_r;
  // ==========================================================
  // Stall pattern
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
  // Slow mode takes one vertex in four cycles to hold outputs waiting
  assign out_ready = presetn && (!slow || cnt_r == 2'h3);
endmodule : vlcp_sink

/* sim/test_vertex_lighting_color_path.sv */
/*
  Self-checking bench: APB defaults and range refusals, vertex stream
  with queued expectations. Assumes vlcp_pkg and vlcp_sink.
*/
`timescale 1ns/1ns
module test_vertex_lighting_color_path;
  import vlcp_pkg::*;
  typedef struct packed {vlcp_vec4_t p; vlcp_vec4_t s; vlcp_fx_t i;
    logic [1:0][VW-1:0] t; logic l;} vlcp_exp_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, err;
  logic in_valid, in_ready, in_first, in_clip, in_last, out_valid, out_ready, out_last;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  vlcp_rgba8_t in_color, in_sec_color;
  logic [IDX_W-1:0] in_index;
  vlcp_vec3_t in_normal;
  vlcp_vec4_t in_position, out_pri, out_sec;
  logic [1:0][VW-1:0] in_tex, out_tex;
  vlcp_fx_t in_clip_t, out_index;
  int fail_count, checks, cyc;
  vlcp_exp_t q[$], e;
  logic [AW-1:0] da[14] = '{12'h100, 12'h10C, 12'h110, 12'h13C, 12'h148, 12'h180,
    12'h210, 12'h290, 12'h29C, 12'h238, 12'h248, 12'h250, 12'h5D4, 12'h000};
  logic [31:0] dv[14] = '{32'h333, 32'h1000, 32'hCCD, 32'h1000, 32'h1000, 32'h333,
    32'h1000, 32'h0, 32'h1000, 32'h1000, 32'hFFF000, 32'hB4000, 32'h1000, 32'h0};

  vlcp_color_path DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .in_valid, .in_ready, .in_color, .in_sec_color,
    .in_index, .in_normal, .in_position, .in_tex, .in_first, .in_clip, .in_clip_t,
    .in_last, .out_valid, .out_ready, .out_pri, .out_sec, .out_index, .out_tex, .out_last);
  vlcp_sink SINK (.pclk, .presetn, .slow, .out_valid, .out_ready);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  function automatic vlcp_fx_t cv(input logic [7:0] c, input logic sg, input logic cl);
    int v;
    v = sg ? 2 * $signed(c) + 1 : int'(c);
    v = v * 16 + (v >>> 4);
    if (cl && v < 0) v = 0;
    if (cl && v > 4096) v = 4096;
    return vlcp_fx_t'(v);
  endfunction : cv

  task automatic chk(input logic ok, input string m);
    checks++;
    if (!ok) begin
      fail_count++;
      $display("[ERR] %0t %s mismatch", $time, m);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // ==========================================================
  // APB master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
                     input logic [31:0] xd, input logic xe);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(err === xe && (w || rd === xd), "apb");
    @(posedge pclk);
  endtask : apb

  // ==========================================================
  // Vertex driver; md uses the control bit layout
  task automatic vtx(input vlcp_rgba8_t pc, input logic [31:0] r, input logic [7:0] md,
                     input logic [1:0] h);
    // h[0]: keep the last colours and index (flat follower, or clip vertex at t = 0)
    // h[1]: keep the last texcoords too and mark the vertex as made by clipping
    if (!h[0]) begin
      for (int k = 0; k < 4; k++) begin
        e.p[k] = md[0] ? (k == 3 ? FX_ONE : 24'h0000A3) : cv(pc[k], md[4], md[1]);
        e.s[k] = md[0] ? (k == 3 ? FX_ONE : FX_ZERO) : cv(r[8*k+:8], md[4], md[1]);
      end
      e.i = {md[3] ? (r[11:0] & 12'h0F0) : r[11:0], 12'h000};
    end
    if (!h[1]) e.t = {r[23:0], pc[23:0]};
    e.l = r[31];
    in_valid <= 1'b1;
    in_color <= pc;
    in_sec_color <= r;
    in_index <= r[11:0];
    in_tex <= e.t;
    in_last <= r[31];
    in_first <= !h[0];
    in_clip <= h[1];
    do begin
      @(posedge pclk);
    end while (in_ready !== 1'b1);
    q.push_back(e);
  endtask : vtx

  // Valid stays up between vertices and drops once after the last take
  task automatic run(input logic [7:0] md, input vlcp_rgba8_t pc);
    apb(1'b1, ADDR_CTRL, {24'h0, md}, 32'h0, 1'b0);
    vtx(pc, ~pc, md, 2'b00);
    repeat (3) begin
      seed = xs(seed);
      vtx(seed, xs(seed), md, {1'b0, md[2]});
    end
    vtx(pc, seed, md, 2'b11);
    in_valid <= 1'b0;
    while (q.size() != 0) begin
      @(posedge pclk);
    end
  endtask : run

  // ==========================================================
  // Result watcher
  always @(posedge pclk) begin
    cyc++;
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (q.size() == 0) chk(1'b0, "extra vertex");
      else chk(q.pop_front() === {out_pri, out_sec, out_index, out_tex, out_last},
               "vertex");
    end
    if (cyc > 20000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, in_valid, in_color, in_sec_color} = '0;
    {in_index, in_normal, in_position, in_tex, in_clip, in_clip_t, in_last} = '0;
    in_first = 1'b1;
    presetn = 1'b0;
    slow = 1'b0;
    seed = 32'h0000_0019;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (da[k]) apb(1'b0, da[k], 32'h0, dv[k], 1'b0);
    apb(1'b1, 12'h390, 32'h123, 32'h0, 1'b0);
    apb(1'b0, 12'h310, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h390, 32'h0, 32'h123, 1'b0);
    apb(1'b1, 12'h250, 32'h05A000, 32'h0, 1'b0);
    apb(1'b1, 12'h250, 32'h05B000, 32'h0, 1'b1);
    apb(1'b0, 12'h250, 32'h0, 32'h05A000, 1'b0);
    apb(1'b1, 12'h254, 32'hFFF000, 32'h0, 1'b1);
    apb(1'b1, 12'h140, 32'h081000, 32'h0, 1'b1);
    apb(1'b0, 12'hFFC, 32'h0, 32'h0, 1'b1);
    apb(1'b1, ADDR_STATUS, 32'h1, 32'h0, 1'b1);
    apb(1'b1, ADDR_IMASK, 32'h0F0, 32'h0, 1'b0);
    slow <= 1'b1;
    run(8'h00, 32'hFF00_7F80);
    run(8'h12, 32'h8000_7F80);
    run(8'h04, 32'h4020_1008);
    slow <= 1'b0;
    run(8'h08, 32'h0102_0304);
    run(8'h01, 32'h0000_0000);
    chk(q.size() == 0, "lost vertex");
    end_sim();
  end
endmodule : test_vertex_lighting_color_path
